// *** rtl/ppx_crossbar.sv ***
`timescale 1ns/1ns
`include "ppx_defines.svh"
module ppx_crossbar (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // special function register access
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    // port pads
    input  wire logic [7:0] pad_in,
    output logic      [7:0] pad_out,
    output logic      [7:0] pad_oe,
    output logic      [7:0] pad_pullup,
    output logic      [7:0] pad_in_en,
    // peripheral signals toward pins
    input  wire logic       uart_tx,
    input  wire logic       smb_sda_drive,
    input  wire logic       smb_scl_drive,
    input  wire logic       comparator_sync_out,
    input  wire logic       comparator_async_out,
    input  wire logic       system_clock_out,
    input  wire logic [2:0] pca_channel_out,
    // pin signals toward peripherals
    output logic            uart_rx,
    output logic            smb_sda_in,
    output logic            smb_scl_in,
    output logic            pca_ext_count_in,
    output logic            timer0_input,
    output logic            timer1_input,
    // external events
    output logic            ext_int0_level,
    output logic            ext_int1_level,
    output logic            ext_int0_edge,
    output logic            ext_int1_edge
);
    import ppx_pkg::*;

    logic [7:0] crossbar_skip_reg_r;
    logic [7:0] crossbar_route_reg_a_r;
    logic [7:0] crossbar_route_reg_b_r;
    logic [7:0] port_input_mode_reg_r;
    logic [7:0] port_output_mode_reg_r;
    logic [7:0] ext_int_pin_config_r;
    logic [7:0] port_latch_r;

    logic [7:0] pin_read;
    logic       crossbar_enable_bit;
    logic       weak_pullup_disable;
    logic [1:0] pca_channel_count;
    logic [2:0] cex_en;
    logic [PPX_NREQ-1:0] req;

    ppx_func_type pin_func_nxt [8];
    ppx_func_type pin_func_r   [8];

    logic [7:0] pad_out_nxt;
    logic [7:0] pad_oe_nxt;
    logic [7:0] pad_pullup_nxt;

    logic       uart_rx_nxt;
    logic       smb_sda_in_nxt;
    logic       smb_scl_in_nxt;
    logic       pca_count_nxt;
    logic       timer0_nxt;
    logic       timer1_nxt;

    logic [2:0] int0_pin;
    logic [2:0] int1_pin;
    logic       int0_nxt;
    logic       int1_nxt;
    logic [7:0] rdata_nxt;

    assign crossbar_enable_bit = crossbar_route_reg_b_r[`PPX_RB_XBAR_EN];
    assign weak_pullup_disable = crossbar_route_reg_b_r[`PPX_RB_WEAK_OFF];
    assign pca_channel_count   =
        crossbar_route_reg_a_r[`PPX_RA_PCA_HI:`PPX_RA_PCA_LO];

    // channel count 0..3 opens channels from 0 upward
    always_comb begin
        cex_en = 3'h0;
        case (pca_channel_count)
            2'h1:    cex_en = 3'h1;
            2'h2:    cex_en = 3'h3;
            2'h3:    cex_en = 3'h7;
            default: cex_en = 3'h0;
        endcase
    end

    // bit order matches placement priority after the serial port
    assign req = {crossbar_route_reg_b_r[`PPX_RB_TIMER1],
                  crossbar_route_reg_b_r[`PPX_RB_TIMER0],
                  crossbar_route_reg_b_r[`PPX_RB_PCA_COUNT],
                  cex_en[2], cex_en[1], cex_en[0],
                  crossbar_route_reg_a_r[`PPX_RA_SYS_CLOCK],
                  crossbar_route_reg_a_r[`PPX_RA_CMPA],
                  crossbar_route_reg_a_r[`PPX_RA_CMPS],
                  crossbar_route_reg_a_r[`PPX_RA_SMB],
                  crossbar_route_reg_a_r[`PPX_RA_SMB]};

    ppx_alloc u_alloc (
        .skip     (crossbar_skip_reg_r),
        .utx_en   (crossbar_route_reg_a_r[`PPX_RA_UTX]),
        .urx_en   (crossbar_route_reg_a_r[`PPX_RA_URX]),
        .req      (req),
        .pin_func (pin_func_nxt)
    );

    // until enabled every pin is a plain port pin
    always_ff @(posedge clock) begin
        for (int p = 0; p < 8; p++) begin
            if (rst || !crossbar_enable_bit) begin
                pin_func_r[p] <= PPX_F_GPIO;
            end else begin
                pin_func_r[p] <= pin_func_nxt[p];
            end
        end
    end

    // analog pins read zero regardless of pad
    assign pin_read = pad_in & port_input_mode_reg_r;

    generate
        for (genvar p = 0; p < 8; p++) begin : g_pin
            logic val;
            logic smb_pin;
            logic push_pull;
            logic drive;

            always_comb begin
                val = 1'b1;
                case (pin_func_r[p])
                    PPX_F_GPIO:   val = port_latch_r[p];
                    PPX_F_UTX:    val = uart_tx;
                    PPX_F_SDA:    val = smb_sda_drive;
                    PPX_F_SCL:    val = smb_scl_drive;
                    PPX_F_CMPS:   val = comparator_sync_out;
                    PPX_F_CMPA:   val = comparator_async_out;
                    PPX_F_SYS_CLOCK: val = system_clock_out;
                    PPX_F_PCA_CH0:   val = pca_channel_out[0];
                    PPX_F_PCA_CH1:   val = pca_channel_out[1];
                    PPX_F_PCA_CH2:   val = pca_channel_out[2];
                    // input functions output high; released only when open-drain
                    default:      val = 1'b1;
                endcase
            end

            assign smb_pin   = (pin_func_r[p] == PPX_F_SDA) ||
                               (pin_func_r[p] == PPX_F_SCL);
            assign push_pull = port_output_mode_reg_r[p] && !smb_pin;
            assign drive     = crossbar_enable_bit &&
                               port_input_mode_reg_r[p];

            // open-drain only ever pulls low
            assign pad_oe_nxt[p]  = drive && (push_pull || !val);
            assign pad_out_nxt[p] = push_pull && val;
            // pull-up off on push-pull while crossbar on, analog and pins driven low
            assign pad_pullup_nxt[p] = port_input_mode_reg_r[p] &&
                                       !weak_pullup_disable &&
                                       !(drive && push_pull) &&
                                       !pad_oe_nxt[p];
        end
    endgenerate

    // unrouted inputs idle high so peripherals see no activity
    always_comb begin
        uart_rx_nxt    = 1'b1;
        smb_sda_in_nxt = 1'b1;
        smb_scl_in_nxt = 1'b1;
        pca_count_nxt  = 1'b1;
        timer0_nxt     = 1'b1;
        timer1_nxt     = 1'b1;
        for (int p = 0; p < 8; p++) begin
            case (pin_func_r[p])
                PPX_F_URX: uart_rx_nxt    = pin_read[p];
                PPX_F_SDA: smb_sda_in_nxt = pin_read[p];
                PPX_F_SCL: smb_scl_in_nxt = pin_read[p];
                PPX_F_PCA_COUNT: pca_count_nxt  = pin_read[p];
                PPX_F_TIMER0:    timer0_nxt     = pin_read[p];
                PPX_F_TIMER1:    timer1_nxt     = pin_read[p];
                default:   ;
            endcase
        end
    end

    // events watch any pin, routed or skipped, but never analog ones
    assign int0_pin = ext_int_pin_config_r[`PPX_EC_INT0_HI:`PPX_EC_INT0_LO];
    assign int1_pin = ext_int_pin_config_r[`PPX_EC_INT1_HI:`PPX_EC_INT1_LO];
    assign int0_nxt = port_input_mode_reg_r[int0_pin] &&
                      (pad_in[int0_pin] ==
                       ext_int_pin_config_r[`PPX_EC_INT0_POL]);
    assign int1_nxt = port_input_mode_reg_r[int1_pin] &&
                      (pad_in[int1_pin] ==
                       ext_int_pin_config_r[`PPX_EC_INT1_POL]);

    always_ff @(posedge clock) begin
        if (rst) begin
            ext_int0_level <= 1'b0;
            ext_int0_edge  <= 1'b0;
        end else begin
            ext_int0_level <= int0_nxt;
            ext_int0_edge  <= int0_nxt && !ext_int0_level;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ext_int1_level <= 1'b0;
            ext_int1_edge  <= 1'b0;
        end else begin
            ext_int1_level <= int1_nxt;
            ext_int1_edge  <= int1_nxt && !ext_int1_level;
        end
    end

    // pads
    always_ff @(posedge clock) begin
        if (rst) begin
            pad_out    <= 8'h00;
            pad_oe     <= 8'h00;
        end else begin
            pad_out    <= pad_out_nxt;
            pad_oe     <= pad_oe_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pad_pullup <= 8'hff;
            pad_in_en  <= 8'hff;
        end else begin
            pad_pullup <= pad_pullup_nxt;
            pad_in_en  <= port_input_mode_reg_r;
        end
    end

    // peripheral inputs
    always_ff @(posedge clock) begin
        if (rst) begin
            uart_rx          <= 1'b1;
            smb_sda_in       <= 1'b1;
            smb_scl_in       <= 1'b1;
            pca_ext_count_in <= 1'b1;
            timer0_input     <= 1'b1;
            timer1_input     <= 1'b1;
        end else begin
            uart_rx          <= uart_rx_nxt;
            smb_sda_in       <= smb_sda_in_nxt;
            smb_scl_in       <= smb_scl_in_nxt;
            pca_ext_count_in <= pca_count_nxt;
            timer0_input     <= timer0_nxt;
            timer1_input     <= timer1_nxt;
        end
    end

    // register writes
    always_ff @(posedge clock) begin
        if (rst) begin
            crossbar_skip_reg_r <= `PPX_RST_SKIP;
        end else if (sfr_wr && sfr_addr == `PPX_ADDR_SKIP) begin
            crossbar_skip_reg_r <= sfr_wdata & `PPX_SKIP_WMASK;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            crossbar_route_reg_a_r <= `PPX_RST_ROUTE_A;
        end else if (sfr_wr && sfr_addr == `PPX_ADDR_ROUTE_A) begin
            crossbar_route_reg_a_r <= sfr_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            crossbar_route_reg_b_r <= `PPX_RST_ROUTE_B;
        end else if (sfr_wr && sfr_addr == `PPX_ADDR_ROUTE_B) begin
            crossbar_route_reg_b_r <= sfr_wdata & `PPX_ROUTE_B_WMASK;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            port_input_mode_reg_r <= `PPX_RST_INMODE;
        end else if (sfr_wr && sfr_addr == `PPX_ADDR_INMODE) begin
            port_input_mode_reg_r <= sfr_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            port_output_mode_reg_r <= `PPX_RST_OUTMODE;
        end else if (sfr_wr && sfr_addr == `PPX_ADDR_OUTMODE) begin
            port_output_mode_reg_r <= sfr_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ext_int_pin_config_r <= `PPX_RST_EXTCFG;
        end else if (sfr_wr && sfr_addr == `PPX_ADDR_EXTCFG) begin
            ext_int_pin_config_r <= sfr_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            port_latch_r <= `PPX_RST_LATCH;
        end else if (sfr_wr && sfr_addr == `PPX_ADDR_PORT) begin
            port_latch_r <= sfr_wdata;
        end
    end

    // register reads; port address returns pad levels, not the latch
    always_comb begin
        rdata_nxt = 8'h00;
        if (sfr_addr == `PPX_ADDR_SKIP) begin
            rdata_nxt = crossbar_skip_reg_r;
        end else if (sfr_addr == `PPX_ADDR_ROUTE_A) begin
            rdata_nxt = crossbar_route_reg_a_r;
        end else if (sfr_addr == `PPX_ADDR_ROUTE_B) begin
            rdata_nxt = crossbar_route_reg_b_r;
        end else if (sfr_addr == `PPX_ADDR_INMODE) begin
            rdata_nxt = port_input_mode_reg_r;
        end else if (sfr_addr == `PPX_ADDR_OUTMODE) begin
            rdata_nxt = port_output_mode_reg_r;
        end else if (sfr_addr == `PPX_ADDR_EXTCFG) begin
            rdata_nxt = ext_int_pin_config_r;
        end else if (sfr_addr == `PPX_ADDR_PORT) begin
            rdata_nxt = pin_read;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= rdata_nxt;
        end
    end

endmodule // ppx_crossbar

// *** rtl/ppx_defines.svh ***
// Notes on behaviour
// - enabled functions take lowest free pin
// - serial tx fixed P0.4, rx fixed P0.5
// - assigned pins skipped for later functions
// - skip-marked pins receive only the fixed serial tx/rx
// - smbus claims two pins, data then clock
// - leftover pins act as plain port pins
// - routing takes effect only once enabled
// - disabled crossbar: inputs only, drivers off
// - input-mode bit: 1 digital, 0 analog
// - analog pin: no pull-up, driver, receiver
// - drive type per output-mode bit; smbus open-drain
// - pull-up on open-drain pins unless disabled
// - pull-up off while pin drives zero
// - edge events on any digital pin
// - no events on analog; any pin selectable
// - skip bits 6:0 writable, bit 7 zero
// - route register: pca count 7:6, single enables
`ifndef PPX_DEFINES_SVH
`define PPX_DEFINES_SVH

`define PPX_ADDR_PORT      8'h80
`define PPX_ADDR_OUTMODE   8'ha4
`define PPX_ADDR_SKIP      8'he1
`define PPX_ADDR_ROUTE_A   8'he2
`define PPX_ADDR_ROUTE_B   8'he3
`define PPX_ADDR_EXTCFG    8'he4
`define PPX_ADDR_INMODE    8'hf1

`define PPX_RST_SKIP       8'h00
`define PPX_RST_ROUTE_A    8'h00
`define PPX_RST_ROUTE_B    8'h00
`define PPX_RST_INMODE     8'hff
`define PPX_RST_OUTMODE    8'h00
`define PPX_RST_LATCH      8'hff
`define PPX_RST_EXTCFG     8'h00

`define PPX_SKIP_WMASK     8'h7f
`define PPX_ROUTE_B_WMASK  8'hc7

`define PPX_RA_PCA_HI      7
`define PPX_RA_PCA_LO      6
`define PPX_RA_CMPA        5
`define PPX_RA_CMPS        4
`define PPX_RA_SYS_CLOCK   3
`define PPX_RA_SMB         2
`define PPX_RA_URX         1
`define PPX_RA_UTX         0

`define PPX_RB_WEAK_OFF    7
`define PPX_RB_XBAR_EN     6
`define PPX_RB_TIMER1      2
`define PPX_RB_TIMER0      1
`define PPX_RB_PCA_COUNT   0

`define PPX_EC_INT0_HI     2
`define PPX_EC_INT0_LO     0
`define PPX_EC_INT0_POL    3
`define PPX_EC_INT1_HI     6
`define PPX_EC_INT1_LO     4
`define PPX_EC_INT1_POL    7

`define PPX_TX_PIN         3'd4
`define PPX_RX_PIN         3'd5

`endif

// *** rtl/ppx_pkg.sv ***
package ppx_pkg;

    // order after the fixed serial pins is the placement priority
    typedef enum logic [3:0] {
        PPX_F_GPIO,
        PPX_F_UTX,
        PPX_F_URX,
        PPX_F_SDA,
        PPX_F_SCL,
        PPX_F_CMPS,
        PPX_F_CMPA,
        PPX_F_SYS_CLOCK,
        PPX_F_PCA_CH0,
        PPX_F_PCA_CH1,
        PPX_F_PCA_CH2,
        PPX_F_PCA_COUNT,
        PPX_F_TIMER0,
        PPX_F_TIMER1
    } ppx_func_type;

    localparam int PPX_NREQ  = 11;
    localparam int PPX_FIRST = 3;

endpackage

// *** rtl/ppx_alloc.sv ***
`timescale 1ns/1ns
module ppx_alloc (
    // configuration
    input  wire logic [7:0]                   skip,
    input  wire logic                         utx_en,
    input  wire logic                         urx_en,
    input  wire logic [ppx_pkg::PPX_NREQ-1:0] req,
    // result
    output ppx_pkg::ppx_func_type             pin_func [8]
);
    import ppx_pkg::*;

    logic [7:0] taken;
    logic       placed;

    always_comb begin
        taken  = skip;
        placed = 1'b0;
        for (int p = 0; p < 8; p++) begin
            pin_func[p] = PPX_F_GPIO;
        end
        // serial pins bypass the skip mask
        if (utx_en) begin
            taken[4]    = 1'b1;
            pin_func[4] = PPX_F_UTX;
        end
        if (urx_en) begin
            taken[5]    = 1'b1;
            pin_func[5] = PPX_F_URX;
        end
        // req bits in priority order; smbus is two bits
        for (int f = 0; f < PPX_NREQ; f++) begin
            placed = 1'b0;
            if (req[f]) begin
                for (int p = 0; p < 8; p++) begin
                    if (!placed && !taken[p]) begin
                        taken[p]    = 1'b1;
                        pin_func[p] = ppx_func_type'(4'(f + PPX_FIRST));
                        placed      = 1'b1;
                    end
                end
            end
        end
    end

endmodule // ppx_alloc

// *** testbench/ppx_crossbar_checker.sv ***
`timescale 1ns/1ns
`include "ppx_defines.svh"
module ppx_crossbar_checker (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // register access
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    // pads
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup,
    input wire logic [7:0] pad_in_en,
    // peripheral and event side
    input wire logic       uart_rx,
    input wire logic       timer0_input,
    input wire logic       ext_int0_level,
    input wire logic       ext_int0_edge
);
    logic [7:0] inmode_r;
    logic [7:0] ecfg_r;
    logic       xbar_r;
    logic       weak_r;
    logic [2:0] quiet_r;
    logic       quiet;

    // shadow copies, so no check needs a view inside
    always_ff @(posedge clock) begin
        if (rst) begin
            inmode_r <= `PPX_RST_INMODE;
            ecfg_r   <= `PPX_RST_EXTCFG;
            xbar_r   <= 1'b0;
            weak_r   <= 1'b0;
        end else if (sfr_wr) begin
            if (sfr_addr == `PPX_ADDR_INMODE) inmode_r <= sfr_wdata;
            if (sfr_addr == `PPX_ADDR_EXTCFG) ecfg_r <= sfr_wdata;
            if (sfr_addr == `PPX_ADDR_ROUTE_B) xbar_r <= sfr_wdata[`PPX_RB_XBAR_EN];
            if (sfr_addr == `PPX_ADDR_ROUTE_B) weak_r <= sfr_wdata[`PPX_RB_WEAK_OFF];
        end
    end

    // mapping pipe is three edges deep; judge only once it has drained
    always_ff @(posedge clock) begin
        if (rst || sfr_wr) begin
            quiet_r <= 3'h0;
        end else if (quiet_r != 3'h7) begin
            quiet_r <= quiet_r + 3'h1;
        end
    end
    assign quiet = (quiet_r >= 3'h5);

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_OFF_NO_DRIVE: assert property (quiet && !xbar_r |-> pad_oe == 8'h00)
        else $error("pad driven while crossbar off");
    AST_OFF_NO_ROUTE: assert property (quiet && !xbar_r |-> uart_rx && timer0_input)
        else $error("routed input seen while crossbar off");
    AST_ANALOG_QUIET: assert property (quiet |-> ((pad_oe | pad_pullup | pad_in_en) & ~inmode_r) == 8'h00)
        else $error("analog pin not isolated");
    AST_INEN_MODE: assert property (quiet |-> pad_in_en == inmode_r)
        else $error("receiver enable differs from input mode");
    AST_PULL_OFF_LOW: assert property ((pad_oe & ~pad_out & pad_pullup) == 8'h00)
        else $error("pull-up on while driving zero");
    AST_WEAK_OFF: assert property (quiet && weak_r |-> pad_pullup == 8'h00)
        else $error("pull-up on while globally disabled");
    AST_EDGE_RISE: assert property ($rose(ext_int0_level) |-> ext_int0_edge)
        else $error("event edge missing");
    AST_EDGE_ONLY: assert property (ext_int0_edge |-> ext_int0_level ##1 !ext_int0_edge)
        else $error("event edge without level or too long");
    AST_EXT_ANALOG: assert property (quiet && !inmode_r[ecfg_r[2:0]] |-> !ext_int0_level)
        else $error("event level on analog pin");
    AST_SKIP_TOP: assert property (sfr_rd && sfr_addr == `PPX_ADDR_SKIP |=> sfr_rdata[7] == 1'b0)
        else $error("skip register top bit reads one");

    cover property (ext_int0_edge);
    cover property (quiet && xbar_r && pad_oe != 8'h00);
    cover property (quiet && weak_r);
endmodule // ppx_crossbar_checker

bind ppx_crossbar ppx_crossbar_checker u_chk (.clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .pad_in_en(pad_in_en), .uart_rx(uart_rx), .timer0_input(timer0_input),
    .ext_int0_level(ext_int0_level), .ext_int0_edge(ext_int0_edge));

// *** testbench/ppx_pad_model.sv ***
`timescale 1ns/1ns
module ppx_pad_model (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // device side
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup,
    output logic     [7:0] pad_in,
    // outside circuits
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val
);
    logic flt_r;

    // an undriven pad wanders, so a missing pull-up cannot pass unseen
    always_ff @(posedge clock) begin
        if (rst) begin
            flt_r <= 1'b0;
        end else begin
            flt_r <= ~flt_r;
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe[i]) pad_in[i] = pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pad_pullup[i]) pad_in[i] = 1'b1;
            else pad_in[i] = flt_r;
        end
    end
endmodule // ppx_pad_model

// *** testbench/priority_port_crossbar_tb.sv ***
`timescale 1ns/1ns
`include "ppx_defines.svh"
module priority_port_crossbar_tb;
    localparam logic [7:0] RADR [8] = '{`PPX_ADDR_SKIP, `PPX_ADDR_ROUTE_A, `PPX_ADDR_ROUTE_B, `PPX_ADDR_INMODE,
                                        `PPX_ADDR_OUTMODE, `PPX_ADDR_EXTCFG, 8'h55, `PPX_ADDR_PORT};
    localparam logic [7:0] RVAL [8] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff};
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic [7:0] sfr_rdata, pad_in, pad_out, pad_oe, pad_pullup, pad_in_en, rv;
    logic       utx = 1'b1, sda = 1'b1, scl = 1'b1, cmps = 1'b1, cmpa = 1'b1, sck = 1'b1;
    logic [2:0] pca = 3'h7;
    logic       urx, sda_in, scl_in, pca_cnt, tmr0, tmr1, e0l, e1l, e0e, e1e;
    logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
    int         error_cnt = 0;
    int         compares = 0;

    always #25 clock = ~clock;

    ppx_crossbar DUT (.clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .pad_in_en(pad_in_en), .uart_tx(utx), .smb_sda_drive(sda), .smb_scl_drive(scl),
        .comparator_sync_out(cmps), .comparator_async_out(cmpa), .system_clock_out(sck), .pca_channel_out(pca),
        .uart_rx(urx), .smb_sda_in(sda_in), .smb_scl_in(scl_in), .pca_ext_count_in(pca_cnt), .timer0_input(tmr0),
        .timer1_input(tmr1), .ext_int0_level(e0l), .ext_int1_level(e1l), .ext_int0_edge(e0e), .ext_int1_edge(e1e));
    ppx_pad_model u_pads (.clock(clock), .rst(rst), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .pad_in(pad_in), .ext_en(ext_en), .ext_val(ext_val));

    task automatic stop_test;
        if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clock);
        sfr_rd = 1'b0;
        @(negedge clock);
        rv = sfr_rdata;
    endtask

    task automatic settle;
        repeat (5) @(negedge clock);
    endtask

    // crossbar off first, so routes never change under a live enable
    task automatic cfg(input logic [7:0] inm, om, sk, ra, rb);
        wr(`PPX_ADDR_ROUTE_B, 8'h00);
        wr(`PPX_ADDR_INMODE, inm);
        wr(`PPX_ADDR_OUTMODE, om);
        wr(`PPX_ADDR_SKIP, sk);
        wr(`PPX_ADDR_ROUTE_A, ra);
        wr(`PPX_ADDR_ROUTE_B, rb);
        settle;
    endtask

    task automatic t_reset;
        for (int i = 0; i < 8; i++) begin
            rd(RADR[i]);
            chk("reset readback", RVAL[i], rv);
        end
        chk("reset oe", 8'h00, pad_oe);
        chk("reset pullup", 8'hff, pad_pullup);
        chk("reset in_en", 8'hff, pad_in_en);
        wr(`PPX_ADDR_SKIP, 8'hff);
        rd(`PPX_ADDR_SKIP);
        chk("skip readback", 8'h7f, rv);
    endtask

    task automatic t_disabled;
        sda = 1'b0;
        cfg(8'hff, 8'h00, 8'h00, 8'h04, 8'h00);
        chk("off oe", 8'h00, pad_oe);
        chk("off inputs", 8'h03, {6'h0, sda_in, scl_in});
    endtask

    task automatic t_smbus;
        cfg(8'hff, 8'h03, 8'h00, 8'h04, 8'h40);
        chk("smbus oe", 8'h01, pad_oe);
        chk("smbus out", 8'h00, {6'h0, pad_out[1:0]});
        chk("smbus pullup", 8'hfe, pad_pullup);
        ext_en = 8'h02;
        settle;
        chk("smbus clock in", 8'h00, {7'h0, scl_in});
        wr(`PPX_ADDR_ROUTE_B, 8'hc0);
        settle;
        chk("weak off", 8'h00, pad_pullup);
        ext_en = 8'h00;
        sda = 1'b1;
    endtask

    task automatic t_skip_uart;
        utx = 1'b0;
        sda = 1'b0;
        scl = 1'b0;
        cfg(8'hff, 8'h00, 8'h0b, 8'h05, 8'h40);
        chk("skip oe", 8'h34, pad_oe);
        sda = 1'b1;
        settle;
        chk("tx fixed", 8'h30, pad_oe);
        utx = 1'b1;
        scl = 1'b1;
    endtask

    task automatic t_prio;
        cmps = 1'b0;
        sck = 1'b0;
        cfg(8'hff, 8'hff, 8'h00, 8'h38, 8'h40);
        chk("prio out", 8'hfa, pad_out);
        chk("gpio oe", 8'hff, pad_oe);
        pca = 3'b100;
        wr(`PPX_ADDR_ROUTE_A, 8'hc0);
        settle;
        chk("pca three", 8'hfc, pad_out);
        wr(`PPX_ADDR_ROUTE_A, 8'h40);
        settle;
        chk("pca one", 8'hfe, pad_out);
        cmps = 1'b1;
        sck = 1'b1;
    endtask

    task automatic t_inputs;
        cfg(8'hff, 8'h00, 8'h00, 8'h00, 8'h47);
        ext_en = 8'h07;
        ext_val = 8'h02;
        settle;
        chk("inputs a", 8'h0a, {4'h0, urx, pca_cnt, tmr0, tmr1});
        ext_val = 8'h05;
        settle;
        chk("inputs b", 8'h0d, {4'h0, urx, pca_cnt, tmr0, tmr1});
        ext_en = 8'h00;
    endtask

    task automatic t_analog;
        cfg(8'hfe, 8'h00, 8'h01, 8'h00, 8'h40);
        ext_en = 8'h02;
        ext_val = 8'h00;
        settle;
        chk("analog in_en", 8'hfe, pad_in_en);
        chk("analog pullup", 8'hfe, pad_pullup);
        rd(`PPX_ADDR_PORT);
        chk("port read", 8'hfc, rv);
        ext_en = 8'h00;
    endtask

    task automatic t_extint;
        logic [1:0] seen;
        seen = 2'h0;
        cfg(8'hff, 8'h00, 8'h00, 8'h00, 8'h40);
        wr(`PPX_ADDR_EXTCFG, 8'h7a);
        ext_en = 8'h84;
        ext_val = 8'h80;
        settle;
        chk("event idle", 8'h00, {6'h0, e0l, e1l});
        ext_val = 8'h04;
        repeat (8) begin
            @(negedge clock);
            seen = seen | {e0e, e1e};
        end
        chk("event edge", 8'h03, {6'h0, seen});
        chk("event level", 8'h03, {6'h0, e0l, e1l});
        wr(`PPX_ADDR_INMODE, 8'hfb);
        settle;
        chk("event analog", 8'h00, {7'h0, e0l});
        ext_en = 8'h00;
    endtask

    initial begin
        repeat (2) @(negedge clock);
        rst = 1'b0;
        t_reset;
        t_disabled;
        t_smbus;
        t_skip_uart;
        t_prio;
        t_inputs;
        t_analog;
        t_extint;
        stop_test;
    end

    // whole sequence needs well under a thousand cycles
    initial begin
        #(3000 * 50);
        error_cnt++;
        stop_test;
    end
endmodule // priority_port_crossbar_tb
